//--- design/ckcr_resolver.sv
// Purpose: Decides the response to an incoming coherent request that hits an outstanding kill.
// Assumes: Requests arrive on a valid/ready port; kill slots are managed by the local agent.
// Notes:   A request that must wait for a final response holds the port until it resolves.
`timescale 1ns/10ps
`default_nettype none
module ckcr_resolver (
  input  wire logic                        sys_clk_i,
  input  wire logic                        resetn_i,
  input  wire logic                        req_valid_i,
  input  wire ckcr_pkg::ckcr_req_e         req_type_i,
  input  wire logic [ckcr_pkg::ADDR_W-1:0] req_addr_i,
  input  wire logic                        req_home_i,
  output var  logic                        req_ready_o,
  input  wire logic                        alloc_i,
  input  wire logic [ckcr_pkg::SLOT_W-1:0] alloc_slot_i,
  input  wire ckcr_pkg::ckcr_kind_e        alloc_kind_i,
  input  wire logic [ckcr_pkg::ADDR_W-1:0] alloc_addr_i,
  input  wire logic                        alloc_sent_i,
  input  wire logic                        issue_i,
  input  wire logic [ckcr_pkg::SLOT_W-1:0] issue_slot_i,
  input  wire logic                        fin_i,
  input  wire logic [ckcr_pkg::SLOT_W-1:0] fin_slot_i,
  input  wire logic                        fin_retry_i,
  input  wire logic                        free_i,
  input  wire logic [ckcr_pkg::SLOT_W-1:0] free_slot_i,
  output var  logic                        res_valid_o,
  output var  ckcr_pkg::ckcr_req_e         res_type_o,
  output var  ckcr_pkg::ckcr_rsp_e         res_resp_o,
  output var  logic                        res_fwd_o,
  output var  logic                        res_cancel_o,
  output var  logic                        res_data_only_o,
  output var  logic                        res_bcast_o,
  output var  logic                        res_normal_o,
  output var  logic                        res_collide_o,
  output var  logic [ckcr_pkg::SLOT_W-1:0] res_slot_o,
  output var  logic                        res_waited_o,
  output var  logic [ckcr_pkg::NSLOT-1:0]  slot_busy_o
);
  import ckcr_pkg::*;

  typedef enum logic {S_IDLE, S_WAIT} ckcr_state_e;

  ckcr_state_e state;
  ckcr_state_e next_state;

  ckcr_req_e            w_type;
  logic [ADDR_W-1:0]    w_addr;
  logic                 w_home;
  logic [SLOT_W-1:0]    w_slot;
  ckcr_kind_e           w_kind;

  logic [NSLOT-1:0]     slot_valid;
  logic [NSLOT-1:0]     slot_hit;
  ckcr_kind_e           slot_kind [NSLOT];
  ckcr_st_e             slot_st   [NSLOT];
  logic [ADDR_W-1:0]    probe;

  // Wait-case helper: pending waits, DONE takes the given action, else ERROR
  function automatic ckcr_act_e wait_or(input ckcr_st_e st, input ckcr_act_e on_done);
    ckcr_act_e a;
    a = ACT_ERROR;
    if (st == ST_PEND) begin
      a = ACT_WAIT;
    end else if (st == ST_DONE) begin
      a = on_done;
    end
    return a;
  endfunction : wait_or

  // Resolution table; used both on arrival and when a waited kill finishes
  function automatic ckcr_act_e decide(input ckcr_kind_e kind, input ckcr_req_e req,
                                       input logic home, input ckcr_st_e st);
    ckcr_act_e a;
    a = ACT_ERROR;
    if (req == REQ_TLBIE || req == REQ_TLBSYNC) begin
      a = ACT_FWD_DONE; // [R9]
    end else begin
      case (kind)
        KIND_DKILL_HOME: begin
          case (req)
            REQ_READ_OWNER:    a = wait_or(st, ACT_INTERV);   // [R2] [R3]
            REQ_RTO_OWNER:     a = wait_or(st, ACT_INTERV);   // [R4] [R3]
            REQ_IO_READ_OWNER: a = wait_or(st, ACT_FWD_DATA); // [R5] [R3]
            REQ_DKILL_SHARER: begin
              if (st == ST_PEND) begin
                a = ACT_WAIT;
              end else if (st == ST_DONE) begin
                a = ACT_ERROR; // [R6]
              end else begin
                a = ACT_CANCEL; // [R7]
              end
            end
            REQ_CASTOUT:       a = ACT_ERROR;    // [R8]
            REQ_IKILL_SHARER:  a = ACT_FWD_DONE; // [R10]
            default:           a = ACT_ERROR;    // [R1]
          endcase
        end
        KIND_DKILL_SHARER: begin
          case (req)
            REQ_READ_HOME, REQ_IREAD_HOME, REQ_RTO_HOME, REQ_DKILL_HOME, REQ_FLUSH:
              a = ACT_RETRY; // [R12]
            REQ_CASTOUT:      a = ACT_ERROR;     // [R8]
            REQ_IKILL_HOME:   a = ACT_FWD_IKILL; // [R11]
            REQ_IO_READ_HOME: begin
              if (home) begin
                a = ACT_RETRY; // [R14]
              end else begin
                a = wait_or(st, ACT_FWD_DATA); // [R15]
              end
            end
            default:          a = ACT_ERROR;     // [R13]
          endcase
        end
        KIND_IKILL_HOME: begin
          case (req)
            REQ_READ_OWNER, REQ_RTO_OWNER, REQ_DKILL_SHARER, REQ_CASTOUT, REQ_IO_READ_OWNER:
              a = ACT_NORMAL; // [R16]
            REQ_IKILL_SHARER: a = ACT_FWD_DONE; // [R10]
            default:          a = ACT_ERROR;    // [R17]
          endcase
        end
        KIND_IKILL_SHARER: begin
          case (req)
            REQ_READ_HOME, REQ_IREAD_HOME, REQ_RTO_HOME, REQ_DKILL_HOME, REQ_CASTOUT, REQ_FLUSH:
              a = ACT_NORMAL; // [R18]
            REQ_IKILL_HOME:   a = ACT_FWD_IKILL; // [R11]
            REQ_IO_READ_HOME: begin
              if (home) begin
                a = ACT_RETRY; // [R14]
              end else begin
                a = wait_or(st, ACT_FWD_DATA); // [R15]
              end
            end
            default:          a = ACT_ERROR;     // [R19]
          endcase
        end
        default: a = ACT_ERROR;
      endcase
    end
    return a;
  endfunction : decide

  // While waiting the slots are probed with the held address, so a freed or reused
  // slot no longer matches and the waiter resolves as if nothing were outstanding
  assign probe = (state == S_WAIT) ? w_addr : req_addr_i;

  genvar gi;
  generate
    for (gi = 0; gi < NSLOT; gi++) begin : g_slot
      ckcr_slot u_slot (
        .sys_clk_i   (sys_clk_i),
        .resetn_i    (resetn_i),
        .alloc_i     (alloc_i && (alloc_slot_i == SLOT_W'(gi))),
        .kind_i      (alloc_kind_i),
        .addr_i      (alloc_addr_i),
        .sent_i      (alloc_sent_i),
        .issue_i     (issue_i && (issue_slot_i == SLOT_W'(gi))),
        .fin_i       (fin_i && (fin_slot_i == SLOT_W'(gi))),
        .fin_retry_i (fin_retry_i),
        .free_i      (free_i && (free_slot_i == SLOT_W'(gi))),
        .probe_i     (probe),
        .valid_o     (slot_valid[gi]),
        .kind_o      (slot_kind[gi]),
        .st_o        (slot_st[gi]),
        .hit_o       (slot_hit[gi])
      );
    end
  endgenerate

  // Lowest numbered matching slot decides when several kills share a granule
  logic [SLOT_W-1:0] hit_idx;
  always_comb begin
    hit_idx = '0;
    for (int i = NSLOT - 1; i >= 0; i--) begin
      if (slot_hit[i]) begin
        hit_idx = SLOT_W'(i);
      end
    end
  end

  wire             any_hit  = |slot_hit;                               // [R21]
  wire ckcr_kind_e hit_kind = slot_kind[hit_idx];
  wire ckcr_st_e   hit_st   = slot_st[hit_idx];
  wire ckcr_st_e   w_st     = slot_hit[w_slot] ? slot_st[w_slot] : ST_NONE;

  wire logic       take     = (state == S_IDLE) && req_valid_i && req_ready_o;
  wire logic       is_tlb   = (req_type_i == REQ_TLBIE) || (req_type_i == REQ_TLBSYNC);

  // A miss is processed normally; CASTOUT has no blocking of its own here [R20]
  wire ckcr_act_e  new_act  = is_tlb   ? ACT_FWD_DONE :                // [R9]
                              !any_hit ? ACT_NORMAL :                  // [R20]
                              decide(hit_kind, req_type_i, req_home_i, hit_st);
  wire ckcr_act_e  w_act    = decide(w_kind, w_type, w_home, w_st);
  wire logic       w_done   = (state == S_WAIT) && (w_act != ACT_WAIT);

  wire logic       emit     = (take && (new_act != ACT_WAIT)) || w_done; // [R21]
  wire ckcr_act_e  emit_act = (state == S_WAIT) ? w_act : new_act;

  always_comb begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (take && (new_act == ACT_WAIT)) begin
          next_state = S_WAIT; // [R2] [R15]
        end
      end
      S_WAIT: begin
        if (w_done) begin
          next_state = S_IDLE;
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  // Action to response and side-effect decode
  wire ckcr_rsp_e next_resp =
    (emit_act == ACT_ERROR)    ? RSP_ERROR :
    (emit_act == ACT_RETRY)    ? RSP_RETRY :
    (emit_act == ACT_INTERV)   ? RSP_INTERV :                          // [R2] [R4]
    (emit_act == ACT_FWD_DATA) ? RSP_DONE_DATA :                       // [R5] [R15]
    (emit_act == ACT_FWD_DONE || emit_act == ACT_CANCEL) ? RSP_DONE :  // [R7] [R9]
    RSP_NONE;
  wire logic next_fwd    = (emit_act == ACT_FWD_DONE) || (emit_act == ACT_FWD_IKILL) ||
                           (emit_act == ACT_FWD_DATA) || (emit_act == ACT_INTERV) ||
                           (emit_act == ACT_CANCEL);
  wire logic next_cancel = (emit_act == ACT_CANCEL);                   // [R7]
  wire logic next_donly  = (emit_act == ACT_INTERV);                   // [R2] [R4]
  wire logic next_bcast  = (emit_act == ACT_FWD_IKILL);                // [R11]
  wire logic next_normal = (emit_act == ACT_NORMAL);                   // [R16] [R18]
  wire logic next_coll   = (state == S_WAIT) || (any_hit && !is_tlb);

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state  <= S_IDLE;
      w_type <= REQ_READ_HOME;
      w_addr <= '0;
      w_home <= 1'b0;
      w_slot <= '0;
      w_kind <= KIND_DKILL_HOME;
    end else begin
      state <= next_state;
      if (take) begin
        w_type <= req_type_i;
        w_addr <= req_addr_i;
        w_home <= req_home_i;
        w_slot <= hit_idx;
        w_kind <= hit_kind;
      end
    end
  end

  // The port stays closed for the whole wait so answers leave in arrival order
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      req_ready_o <= 1'b0;
      slot_busy_o <= '0;
    end else begin
      req_ready_o <= (next_state == S_IDLE);
      slot_busy_o <= slot_valid;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      res_valid_o     <= 1'b0;
      res_type_o      <= REQ_READ_HOME;
      res_resp_o      <= RSP_NONE;
      res_fwd_o       <= 1'b0;
      res_cancel_o    <= 1'b0;
      res_data_only_o <= 1'b0;
      res_bcast_o     <= 1'b0;
      res_normal_o    <= 1'b0;
      res_collide_o   <= 1'b0;
      res_slot_o      <= '0;
      res_waited_o    <= 1'b0;
    end else begin
      res_valid_o     <= emit; // [R21]
      res_fwd_o       <= emit && next_fwd;
      res_cancel_o    <= emit && next_cancel;
      res_data_only_o <= emit && next_donly;
      res_bcast_o     <= emit && next_bcast;
      res_normal_o    <= emit && next_normal;
      if (emit) begin
        res_type_o    <= (state == S_WAIT) ? w_type : req_type_i;
        res_resp_o    <= next_resp;
        res_collide_o <= next_coll;
        res_slot_o    <= (state == S_WAIT) ? w_slot : hit_idx;
        res_waited_o  <= (state == S_WAIT);
      end
    end
  end

endmodule : ckcr_resolver
`default_nettype wire

//--- design/ckcr_pkg.sv
// Purpose: Shared constants and types of the coherence kill collision resolver.
// Assumes: One clock; incoming requests arrive one at a time on a valid/ready port.
// Notes:   Only data and instruction cache kills are tracked as outstanding work.
// Behaviour
// R1: Outstanding DKILL_HOME: home-side reads, kills, flush, I/O read home get ERROR.
// R2: READ_OWNER against DKILL_HOME waits; DONE gives forward, intervention and data-only.
// R3: Owner reads against DKILL_HOME get ERROR on RETRY or when nothing is outstanding.
// R4: READ_TO_OWN_OWNER against DKILL_HOME on DONE: forward, intervention and data-only.
// R5: IO_READ_OWNER against DKILL_HOME on DONE: forward, then DONE with data.
// R6: DKILL_SHARER against DKILL_HOME finished DONE gets ERROR, granule is owned.
// R7: DKILL_SHARER against DKILL_HOME on RETRY or none: cancel invalidate, forward, DONE.
// R8: CASTOUT against an outstanding data cache kill gets ERROR.
// R9: TLBIE and TLBSYNC never collide; forward to processor and reply DONE.
// R10: IKILL_SHARER during DKILL_HOME or IKILL_HOME: forward and reply DONE.
// R11: IKILL_HOME during a sharer kill: forward and send IKILL_SHARER to others.
// R12: Outstanding DKILL_SHARER: home reads, DKILL_HOME and FLUSH get RETRY.
// R13: Outstanding DKILL_SHARER: owner reads, sharer kills, I/O read owner get ERROR.
// R14: IO_READ_HOME against a sharer kill at the home element gets RETRY.
// R15: Non-home IO_READ_HOME waits; DONE forwards with data, otherwise ERROR.
// R16: Outstanding IKILL_HOME: owner reads, DKILL_SHARER, CASTOUT pass as no collision.
// R17: Outstanding IKILL_HOME: home reads, home kills, flush, I/O read home get ERROR.
// R18: Outstanding IKILL_SHARER: home reads, DKILL_HOME, CASTOUT, FLUSH pass normally.
// R19: Outstanding IKILL_SHARER: owner reads, sharer kills, I/O read owner get ERROR.
// R20: CASTOUT bypasses collision blocking and goes on to normal directory update; here only on a miss or an IKILL hit, a DKILL hit gives ERROR.
// R21: Compare granule addresses with outstanding kills; exactly one resolution per request.
package ckcr_pkg;

  localparam int ADDR_W   = 32;
  localparam int GRAN_LSB = 5;
  localparam int NSLOT    = 4;
  localparam int SLOT_W   = 2;

  typedef enum logic [3:0] {
    REQ_READ_HOME, REQ_IREAD_HOME, REQ_READ_OWNER, REQ_RTO_HOME, REQ_RTO_OWNER,
    REQ_DKILL_HOME, REQ_DKILL_SHARER, REQ_CASTOUT, REQ_TLBIE, REQ_TLBSYNC,
    REQ_IKILL_HOME, REQ_IKILL_SHARER, REQ_FLUSH, REQ_IO_READ_HOME, REQ_IO_READ_OWNER
  } ckcr_req_e;

  typedef enum logic [1:0] {KIND_DKILL_HOME, KIND_DKILL_SHARER, KIND_IKILL_HOME, KIND_IKILL_SHARER} ckcr_kind_e;

  // Outstanding state of a tracked kill as seen by a colliding request
  typedef enum logic [1:0] {ST_NONE, ST_PEND, ST_DONE, ST_RETRY} ckcr_st_e;

  typedef enum logic [2:0] {RSP_NONE, RSP_DONE, RSP_DONE_DATA, RSP_INTERV, RSP_RETRY, RSP_ERROR} ckcr_rsp_e;

  typedef enum logic [3:0] {
    ACT_NORMAL, ACT_ERROR, ACT_RETRY, ACT_FWD_DONE, ACT_FWD_IKILL,
    ACT_FWD_DATA, ACT_INTERV, ACT_CANCEL, ACT_WAIT
  } ckcr_act_e;

endpackage : ckcr_pkg

//--- design/ckcr_slot.sv
// Purpose: One tracked outstanding kill with its granule tag and final response.
// Assumes: Allocation, issue, final response and release come from the local agent.
// Notes:   Allocation wins over release in the same cycle.
`timescale 1ns/10ps
`default_nettype none
module ckcr_slot (
  input  wire logic                      sys_clk_i,
  input  wire logic                      resetn_i,
  input  wire logic                      alloc_i,
  input  wire ckcr_pkg::ckcr_kind_e      kind_i,
  input  wire logic [ckcr_pkg::ADDR_W-1:0] addr_i,
  input  wire logic                      sent_i,
  input  wire logic                      issue_i,
  input  wire logic                      fin_i,
  input  wire logic                      fin_retry_i,
  input  wire logic                      free_i,
  input  wire logic [ckcr_pkg::ADDR_W-1:0] probe_i,
  output var  logic                      valid_o,
  output var  ckcr_pkg::ckcr_kind_e      kind_o,
  output var  ckcr_pkg::ckcr_st_e        st_o,
  output var  logic                      hit_o
);
  import ckcr_pkg::*;

  logic [ADDR_W-GRAN_LSB-1:0] tag;
  logic                       sent;
  logic                       fin;
  logic                       retry;

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      valid_o <= 1'b0;
      kind_o  <= KIND_DKILL_HOME;
      tag     <= '0;
      sent    <= 1'b0;
      fin     <= 1'b0;
      retry   <= 1'b0;
    end else if (alloc_i) begin
      valid_o <= 1'b1;
      kind_o  <= kind_i;
      tag     <= addr_i[ADDR_W-1:GRAN_LSB];
      sent    <= sent_i;
      fin     <= 1'b0;
      retry   <= 1'b0;
    end else if (free_i) begin
      valid_o <= 1'b0;
    end else begin
      if (issue_i) begin
        sent <= 1'b1;
      end
      if (fin_i && valid_o && sent) begin
        fin   <= 1'b1;
        retry <= fin_retry_i;
      end
    end
  end

  // Granule compare ignores the offset bits below the granule size [R21]
  assign hit_o = valid_o && (tag == probe_i[ADDR_W-1:GRAN_LSB]);
  assign st_o  = !sent ? ST_NONE : !fin ? ST_PEND : retry ? ST_RETRY : ST_DONE;

endmodule : ckcr_slot
`default_nettype wire

//--- testbench/ckcr_resolver_checker.sv
// Purpose: Port checks of the resolver.
// Assumes: One clock, async active-low reset.
// Notes:   Waits are unbounded; no result may appear while held, and the release must carry a result.
`timescale 1ns/10ps
`default_nettype none
module ckcr_resolver_checker
  import ckcr_pkg::*;
(
  input wire logic                sys_clk_i,
  input wire logic                resetn_i,
  input wire logic                req_valid_i,
  input wire logic                req_ready_o,
  input wire logic                res_valid_o,
  input wire ckcr_pkg::ckcr_req_e res_type_o,
  input wire ckcr_pkg::ckcr_rsp_e res_resp_o,
  input wire logic                res_fwd_o,
  input wire logic                res_cancel_o,
  input wire logic                res_data_only_o,
  input wire logic                res_bcast_o,
  input wire logic                res_normal_o,
  input wire logic                res_collide_o,
  input wire logic                res_waited_o
);
  logic started;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  // Ready rises once after reset with no result
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      started <= 1'b0;
    end else if (req_ready_o) begin
      started <= 1'b1;
    end
  end
  a_take_answer: assert property (req_valid_i && req_ready_o |=> res_valid_o || !req_ready_o)
    else $error("request not answered");
  a_wait_quiet: assert property (started && !req_ready_o |-> !res_valid_o)
    else $error("result while held");
  a_rise_result: assert property (started && $rose(req_ready_o) |-> res_valid_o && res_waited_o)
    else $error("release without result");
  a_pulse_valid: assert property (res_fwd_o || res_cancel_o || res_data_only_o || res_bcast_o || res_normal_o
    |-> res_valid_o)
    else $error("pulse without result");
  a_interv_pair: assert property (res_valid_o && res_resp_o == RSP_INTERV |-> res_fwd_o && res_data_only_o
    && res_collide_o)
    else $error("bad intervention");
  a_cancel_done: assert property (res_cancel_o |-> res_fwd_o && res_resp_o == RSP_DONE
    && res_type_o == REQ_DKILL_SHARER)
    else $error("bad cancel");
  a_tlb_pass: assert property (res_valid_o && res_type_o inside {REQ_TLBIE, REQ_TLBSYNC}
    |-> res_fwd_o && !res_collide_o && res_resp_o == RSP_DONE)
    else $error("TLB op collided");
  a_bcast_ikill: assert property (res_bcast_o |-> res_fwd_o && res_type_o == REQ_IKILL_HOME
    && res_resp_o == RSP_NONE)
    else $error("bad broadcast");
  a_normal_quiet: assert property (res_normal_o |-> !res_fwd_o && res_resp_o == RSP_NONE)
    else $error("bad normal");
  a_result_held: assert property (!res_valid_o |-> $stable(res_resp_o) && $stable(res_type_o))
    else $error("result fields moved");
  a_done_data: assert property (res_valid_o && res_resp_o == RSP_DONE_DATA |-> res_fwd_o && res_collide_o)
    else $error("bad data reply");
  c_waited: cover property (res_valid_o && res_waited_o);
  c_bcast: cover property (res_bcast_o);
  c_cancel: cover property (res_cancel_o);
endmodule : ckcr_resolver_checker
bind ckcr_resolver ckcr_resolver_checker u_checker (.*);
`default_nettype wire

//--- testbench/ckcr_agent_model.sv
// Purpose: Local agent for the kill slots.
// Assumes: Tasks start after a falling edge.
// Notes:   One-cycle pulses; released address, sent and retry fields read inverted.
`timescale 1ns/10ps
`default_nettype none
module ckcr_agent_model
  import ckcr_pkg::*;
(
  input  wire logic                        sys_clk_i,
  output var  logic                        alloc_o,
  output var  logic [ckcr_pkg::SLOT_W-1:0] alloc_slot_o,
  output var  ckcr_pkg::ckcr_kind_e        alloc_kind_o,
  output var  logic [ckcr_pkg::ADDR_W-1:0] alloc_addr_o,
  output var  logic                        alloc_sent_o,
  output var  logic                        issue_o,
  output var  logic [ckcr_pkg::SLOT_W-1:0] issue_slot_o,
  output var  logic                        fin_o,
  output var  logic [ckcr_pkg::SLOT_W-1:0] fin_slot_o,
  output var  logic                        fin_retry_o,
  output var  logic                        free_o,
  output var  logic [ckcr_pkg::SLOT_W-1:0] free_slot_o
);
  initial begin
    {alloc_o, alloc_sent_o, issue_o, fin_o, fin_retry_o, free_o} = 6'h00;
    {alloc_slot_o, issue_slot_o, fin_slot_o, free_slot_o} = 8'h00;
    alloc_addr_o = 32'h0;
    alloc_kind_o = KIND_DKILL_HOME;
  end
  task automatic put(input logic [SLOT_W-1:0] s, input ckcr_kind_e k, input logic [ADDR_W-1:0] a,
                     input logic sent);
    alloc_o      = 1'b1;
    alloc_slot_o = s;
    alloc_kind_o = k;
    alloc_addr_o = a;
    alloc_sent_o = sent;
    @(negedge sys_clk_i);
    alloc_o      = 1'b0;
    alloc_addr_o = ~a;
    alloc_sent_o = ~sent;
  endtask : put
  task automatic issue(input logic [SLOT_W-1:0] s);
    issue_o      = 1'b1;
    issue_slot_o = s;
    @(negedge sys_clk_i);
    issue_o      = 1'b0;
  endtask : issue
  task automatic finish(input logic [SLOT_W-1:0] s, input logic retry);
    fin_o       = 1'b1;
    fin_slot_o  = s;
    fin_retry_o = retry;
    @(negedge sys_clk_i);
    fin_o       = 1'b0;
    fin_retry_o = ~retry;
  endtask : finish
  task automatic drop(input logic [SLOT_W-1:0] s);
    free_o      = 1'b1;
    free_slot_o = s;
    @(negedge sys_clk_i);
    free_o      = 1'b0;
  endtask : drop
endmodule : ckcr_agent_model
`default_nettype wire

//--- testbench/tb_top.sv
// Purpose: Resolver bench.
// Assumes: Inputs change on the falling edge.
// Notes:   Final responses come late.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import ckcr_pkg::*;
  localparam logic [ADDR_W-1:0] BASE = 32'h0000_1000;
  // Response, then fwd, bcast, normal, cancel, data-only
  localparam logic [7:0] FD = {RSP_DONE, 5'b10000};
  localparam logic [7:0] ER = {RSP_ERROR, 5'b00000};
  localparam logic [7:0] RT = {RSP_RETRY, 5'b00000};
  localparam logic [7:0] NM = {RSP_NONE, 5'b00100};
  localparam logic [7:0] BC = {RSP_NONE, 5'b11000};
  localparam logic [7:0] IV = {RSP_INTERV, 5'b10001};
  localparam logic [7:0] DD = {RSP_DONE_DATA, 5'b10000};
  localparam logic [7:0] CN = {RSP_DONE, 5'b10010};
  logic              sys_clk_i, resetn_i, req_valid_i, req_home_i, req_ready_o;
  ckcr_req_e         req_type_i, res_type_o;
  logic [ADDR_W-1:0] req_addr_i, alloc_addr_i;
  logic              alloc_i, alloc_sent_i, issue_i, fin_i, fin_retry_i, free_i;
  logic [SLOT_W-1:0] alloc_slot_i, issue_slot_i, fin_slot_i, free_slot_i, res_slot_o;
  ckcr_kind_e        alloc_kind_i;
  ckcr_rsp_e         res_resp_o;
  logic              res_valid_o, res_fwd_o, res_cancel_o, res_data_only_o, res_bcast_o;
  logic              res_normal_o, res_collide_o, res_waited_o;
  logic [NSLOT-1:0]  slot_busy_o;
  int                bad_count, num_checks;
  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  ckcr_resolver dut (.*);
  ckcr_agent_model agent (.sys_clk_i(sys_clk_i), .alloc_o(alloc_i), .alloc_slot_o(alloc_slot_i),
    .alloc_kind_o(alloc_kind_i), .alloc_addr_o(alloc_addr_i), .alloc_sent_o(alloc_sent_i), .issue_o(issue_i),
    .issue_slot_o(issue_slot_i), .fin_o(fin_i), .fin_slot_o(fin_slot_i), .fin_retry_o(fin_retry_i),
    .free_o(free_i), .free_slot_o(free_slot_i));
  task automatic conclude();
    $display("checks=%0d errors=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic hang();
    bad_count++;
    conclude();
  endtask : hang
  function automatic logic [7:0] exp_of(input ckcr_kind_e k, input ckcr_req_e r);
    logic hg;
    hg = r inside {REQ_READ_HOME, REQ_IREAD_HOME, REQ_RTO_HOME, REQ_DKILL_HOME, REQ_FLUSH};
    if (r inside {REQ_TLBIE, REQ_TLBSYNC}) return FD;
    case (k)
      KIND_DKILL_HOME: return (r == REQ_IKILL_SHARER) ? FD : ER;
      KIND_DKILL_SHARER: return (hg || r == REQ_IO_READ_HOME) ? RT : (r == REQ_IKILL_HOME) ? BC : ER;
      KIND_IKILL_HOME: return (hg || r inside {REQ_IKILL_HOME, REQ_IO_READ_HOME}) ? ER :
                              (r == REQ_IKILL_SHARER) ? FD : NM;
      default: return (hg || r == REQ_CASTOUT) ? NM : (r == REQ_IKILL_HOME) ? BC :
                      (r == REQ_IO_READ_HOME) ? RT : ER;
    endcase
  endfunction : exp_of
  // Address reads inverted once taken
  task automatic send(input ckcr_req_e t, input logic [ADDR_W-1:0] a, input logic h);
    req_valid_i = 1'b1;
    req_type_i  = t;
    req_addr_i  = a;
    req_home_i  = h;
    for (int n = 0; n < 50 && req_ready_o !== 1'b1; n++) begin
      @(negedge sys_clk_i);
    end
    if (req_ready_o !== 1'b1) hang();
    @(negedge sys_clk_i);
    req_valid_i = 1'b0;
    req_addr_i  = ~a;
  endtask : send
  task automatic get(input ckcr_req_e t, input logic [7:0] ex, input logic col, input logic wt);
    for (int n = 0; n < 40 && res_valid_o !== 1'b1; n++) begin
      @(negedge sys_clk_i);
    end
    if (res_valid_o !== 1'b1) hang();
    chk({res_type_o, res_resp_o, res_fwd_o, res_bcast_o, res_normal_o, res_cancel_o, res_data_only_o,
         res_collide_o, res_waited_o}, {t, ex, col, wt});
    @(negedge sys_clk_i);
  endtask : get
  task automatic t_matrix();
    ckcr_kind_e k;
    ckcr_req_e r;
    for (int i = 0; i < 4; i++) begin
      k = ckcr_kind_e'(i);
      agent.put(2'h0, k, BASE, 1'b1);
      for (int j = 0; j < 15; j++) begin
        r = ckcr_req_e'(j);
        if (!(k == KIND_DKILL_HOME && r inside {REQ_READ_OWNER, REQ_RTO_OWNER, REQ_IO_READ_OWNER, REQ_DKILL_SHARER})) begin
          send(r, BASE | 32'h1f, 1'b1);
          get(r, exp_of(k, r), !(r inside {REQ_TLBIE, REQ_TLBSYNC}), 1'b0);
        end
      end
      agent.drop(2'h0);
    end
  endtask : t_matrix
  task automatic t_wait(input ckcr_kind_e k, input ckcr_req_e r, input logic h, input logic rt, input logic [7:0] ex);
    agent.put(2'h1, k, BASE, 1'b1);
    send(r, BASE, h);
    repeat (3) begin
      chk({req_ready_o, res_valid_o}, 16'h0000);
      @(negedge sys_clk_i);
    end
    agent.finish(2'h1, rt);
    get(r, ex, 1'b1, 1'b1);
    chk(16'(res_slot_o), 16'h0001);
    agent.drop(2'h1);
  endtask : t_wait
  task automatic t_noout();
    agent.put(2'h2, KIND_DKILL_HOME, BASE, 1'b0);
    send(REQ_IO_READ_OWNER, BASE, 1'b1);
    get(REQ_IO_READ_OWNER, ER, 1'b1, 1'b0);
    send(REQ_DKILL_SHARER, BASE, 1'b1);
    get(REQ_DKILL_SHARER, CN, 1'b1, 1'b0);
    agent.issue(2'h2);
    send(REQ_READ_OWNER, BASE, 1'b1);
    agent.finish(2'h2, 1'b0);
    get(REQ_READ_OWNER, IV, 1'b1, 1'b1);
    agent.put(2'h2, KIND_IKILL_SHARER, BASE, 1'b0);
    send(REQ_IO_READ_HOME, BASE, 1'b0);
    get(REQ_IO_READ_HOME, ER, 1'b1, 1'b0);
    agent.drop(2'h2);
  endtask : t_noout
  task automatic t_miss();
    agent.put(2'h3, KIND_DKILL_HOME, BASE, 1'b1);
    send(REQ_CASTOUT, BASE + 32'h20, 1'b1);
    get(REQ_CASTOUT, NM, 1'b0, 1'b0);
    send(REQ_CASTOUT, BASE, 1'b1);
    get(REQ_CASTOUT, ER, 1'b1, 1'b0);
    chk(16'(slot_busy_o), 16'h0008);
    agent.drop(2'h3);
  endtask : t_miss
  initial begin
    resetn_i    = 1'b0;
    req_valid_i = 1'b0;
    req_type_i  = REQ_READ_HOME;
    req_addr_i  = 32'h0;
    req_home_i  = 1'b0;
    repeat (8) @(negedge sys_clk_i);
    chk({req_ready_o, res_valid_o}, 16'h0000);
    resetn_i = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    t_matrix();
    t_wait(KIND_DKILL_HOME, REQ_READ_OWNER, 1'b1, 1'b0, IV);
    t_wait(KIND_DKILL_HOME, REQ_RTO_OWNER, 1'b1, 1'b0, IV);
    t_wait(KIND_DKILL_HOME, REQ_IO_READ_OWNER, 1'b1, 1'b0, DD);
    t_wait(KIND_DKILL_HOME, REQ_RTO_OWNER, 1'b1, 1'b1, ER);
    t_wait(KIND_DKILL_HOME, REQ_DKILL_SHARER, 1'b1, 1'b0, ER);
    t_wait(KIND_DKILL_HOME, REQ_DKILL_SHARER, 1'b1, 1'b1, CN);
    t_wait(KIND_DKILL_SHARER, REQ_IO_READ_HOME, 1'b0, 1'b0, DD);
    t_wait(KIND_IKILL_SHARER, REQ_IO_READ_HOME, 1'b0, 1'b1, ER);
    t_noout();
    t_miss();
    conclude();
  end
endmodule : tb_top
`default_nettype wire
